// File: cpmst_pkg.sv
// cpmst_pkg: constants, codes and carriers of the cpu register state block.
// assumes a single cpu clock domain; data values are byte or word wide, state and alu codes three and four bits.
package cpmst_pkg;
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [7:0] SP_LOW_REINIT = 8'hff;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_BRK = 16'hfffc;
    localparam logic [15:0] VEC_BRK_MON = 16'hfefc;
    localparam logic [15:0] VEC_IRQ_TOP = 16'hfffa;
    localparam int CCR_C = 0;
    localparam int CCR_Z = 1;
    localparam int CCR_N = 2;
    localparam int CCR_I = 3;
    localparam int CCR_H = 4;
    localparam int CCR_V = 7;
    localparam logic [7:0] CCR_ONES = 8'h60;
    localparam logic [7:0] CCR_RESET = CCR_ONES | 8'h08;
    localparam logic [7:0] OFS_WORK = 8'h00;
    localparam logic [7:0] OFS_INDEX = 8'h04;
    localparam logic [7:0] OFS_STACK = 8'h08;
    localparam logic [7:0] OFS_PROG = 8'h0c;
    localparam logic [7:0] OFS_CCR = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam int STOP_RECOVERY_CYC = 32;
    localparam int STACK_BYTES = 5;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_STACK = 3'b001,
        ST_VEC_HI = 3'b010,
        ST_VEC_LO = 3'b011,
        ST_UNSTACK = 3'b100,
        ST_WAIT = 3'b101,
        ST_STOP = 3'b110
    } cpmst_state_t;

    typedef enum logic [3:0] {
        ALU_ADD = 4'h0,
        ALU_ADC = 4'h1,
        ALU_SUB = 4'h2,
        ALU_SBC = 4'h3,
        ALU_AND = 4'h4,
        ALU_OR = 4'h5,
        ALU_EOR = 4'h6,
        ALU_MOV = 4'h7,
        ALU_ASL = 4'h8,
        ALU_LSR = 4'h9,
        ALU_ROL = 4'ha,
        ALU_ROR = 4'hb,
        ALU_BTST = 4'hc
    } cpmst_aluop_t;

    typedef struct packed {
        logic valid;
        cpmst_aluop_t op;
        logic [7:0] opnd;
        logic bitIn;
    } cpmst_alu_t;
endpackage : cpmst_pkg

// File: cpmst_core.sv
// cpmst_core: working, index, stack, program counter and condition code state.
// assumes the sequencer pulses its ops only in run state, one instruction at a time.
// Operation
// - eight-bit working register holds operands, results
// - sixteen-bit index pair, high and low bytes
// - reset loads stack pointer with 00ff
// - stack low reinit sets low byte ff
// - stack pointer decrements on push, increments pull
// - program counter increments per fetch, loads otherwise
// - leaving reset, fetch vector from fffe/ffff
// - condition code bits six, five read one
// - overflow flag follows two's complement overflow
// - nibble carry set on add bit-three carry
// - mask blocks irqs; set after stacking, before vector
// - interrupt entry never stacks index high byte
// - highest priority pending request served first
// - interrupt return restores stacked registers and mask
// - reset sets mask; clear, wait and stop ops clear
// - negative flag copies result bit seven
// - zero flag set on zero result
// - carry from add, borrow, test, shifts
// - wait clears mask, stops cpu clock
// - stop clears mask, restart after recovery delay
// - break loads soft irq opcode, break vector
// - break after instruction; return ends if released
`timescale 1ns/10ps
module cpmst_core #(
    parameter int IRQ_N = 4,
    parameter logic [IRQ_N-1:0] IRQ_EXT = '1,
    parameter int STOP_CYC = cpmst_pkg::STOP_RECOVERY_CYC,
    parameter logic [7:0] SWI_OPCODE = 8'h00 // arbitrary value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrEnd,
    input wire logic pcInc,
    input wire logic pcLoad,
    input wire logic [15:0] pcLoadVal,
    input wire logic irLoad,
    input wire logic [7:0] irVal,
    input wire cpmst_pkg::cpmst_alu_t alu,
    input wire logic hxLoad,
    input wire logic [15:0] hxVal,
    input wire logic spLoad,
    input wire logic [15:0] spVal,
    input wire logic spPush,
    input wire logic spPull,
    input wire logic stackLowReinit,
    input wire logic maskClearOp,
    input wire logic maskSetOp,
    input wire logic interruptReturnOp,
    input wire logic waitOp,
    input wire logic stopOp,
    input wire logic [IRQ_N-1:0] irqPend,
    output logic irqAck,
    output logic [3:0] irqId,
    input wire logic brkReq,
    input wire logic brkLastCycle,
    input wire logic monMode,
    output logic brkActive,
    output logic memReq,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata,
    input wire logic memAck,
    output logic [7:0] workReg,
    output logic [15:0] indexPair,
    output logic [15:0] stackPtr,
    output logic [15:0] progCnt,
    output logic [7:0] ccrOut,
    output logic [7:0] instrReg,
    output logic cpuClkEn
);
    import cpmst_pkg::*;

    if (IRQ_N < 1 || IRQ_N > 16 || STOP_CYC < 1 || STOP_CYC > 65535) begin : g_bad
        $error("cpmst_core: parameter out of range");
    end

    cpmst_state_t stR, stNxt;
    logic [7:0] aR, aNxt, ccrR, ccrNxt, irR, irNxt;
    logic [15:0] hxR, hxNxt, spR, spNxt, pcR, pcNxt, vecR, vecNxt, dlyR, dlyNxt;
    logic [2:0] idxR, idxNxt;
    logic brkR, brkNxt, wakeR, wakeNxt;

    function automatic logic [3:0] cpmstPrio(input logic [IRQ_N-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = IRQ_N - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = k[3:0];
            end
        end
        return r;
    endfunction : cpmstPrio

    wire run = (stR == ST_RUN);
    wire iBit = ccrR[CCR_I];
    wire [7:0] ccrView = ccrR | CCR_ONES;
    wire [IRQ_N-1:0] irqLive = irqPend & {IRQ_N{~iBit}};
    wire irqAny = |irqLive;
    wire [3:0] irqSel = cpmstPrio(irqLive);
    wire [15:0] irqVec = VEC_IRQ_TOP - {11'h000, irqSel, 1'b0};
    // an address match on the last cycle is taken at once, not one instruction late
    wire brkStart = run & brkReq & ~brkR & (instrEnd | brkLastCycle);
    wire irqStart = run & instrEnd & irqAny & ~brkStart;
    wire stopDone = (stR == ST_STOP) & wakeR & (dlyR == 16'(STOP_CYC - 1));
    wire waitWake = (stR == ST_WAIT) & irqAny;

    // alu and flags
    logic [7:0] aluRes;
    logic aluC, aluV, aluH, aluWr, aluNz, updC, updV, updH;
    logic [8:0] sum9;
    logic [4:0] sum5;
    wire cin = ccrR[CCR_C] & (alu.op == ALU_ADC || alu.op == ALU_SBC);

    always_comb begin
        sum9 = {1'b0, aR} + {1'b0, alu.opnd} + {8'h00, cin};
        sum5 = {1'b0, aR[3:0]} + {1'b0, alu.opnd[3:0]} + {4'h0, cin};
        aluRes = aR;
        aluC = ccrR[CCR_C];
        aluV = 1'b0;
        aluH = ccrR[CCR_H];
        aluWr = 1'b1;
        aluNz = 1'b1;
        updC = 1'b1;
        updV = 1'b1;
        updH = 1'b0;
        case (alu.op)
            ALU_ADD, ALU_ADC: begin
                aluRes = sum9[7:0];
                aluC = sum9[8];
                aluH = sum5[4];
                updH = 1'b1;
                aluV = (aR[7] == alu.opnd[7]) & (sum9[7] != aR[7]);
            end
            ALU_SUB, ALU_SBC: begin
                sum9 = {1'b0, aR} - {1'b0, alu.opnd} - {8'h00, cin};
                aluRes = sum9[7:0];
                aluC = sum9[8];
                aluV = (aR[7] != alu.opnd[7]) & (sum9[7] != aR[7]);
            end
            ALU_AND, ALU_OR, ALU_EOR, ALU_MOV: begin
                updC = 1'b0;
                case (alu.op)
                    ALU_AND: aluRes = aR & alu.opnd;
                    ALU_OR: aluRes = aR | alu.opnd;
                    ALU_EOR: aluRes = aR ^ alu.opnd;
                    default: aluRes = alu.opnd;
                endcase
            end
            ALU_ASL, ALU_ROL: begin
                aluRes = {aR[6:0], (alu.op == ALU_ROL) & ccrR[CCR_C]};
                aluC = aR[7];
                aluV = aluRes[7] ^ aR[7];
            end
            ALU_LSR, ALU_ROR: begin
                aluRes = {(alu.op == ALU_ROR) & ccrR[CCR_C], aR[7:1]};
                aluC = aR[0];
                aluV = aluRes[7] ^ aR[0];
            end
            ALU_BTST: begin
                aluC = alu.bitIn;
                aluWr = 1'b0;
                aluNz = 1'b0;
                updV = 1'b0;
            end
            default: begin
                aluWr = 1'b0;
                aluNz = 1'b0;
                updC = 1'b0;
                updV = 1'b0;
            end
        endcase
    end

    // register bus decode
    wire hit = (paddr == OFS_WORK) | (paddr == OFS_INDEX) | (paddr == OFS_STACK) |
        (paddr == OFS_PROG) | (paddr == OFS_CCR) | (paddr == OFS_STAT);
    wire apbWr = psel & penable & pwrite & hit;
    wire [31:0] statWord = {26'h0000000, brkR, cpuClkEn, wakeR, stR};
    wire [31:0] rdMux = (paddr == OFS_WORK) ? {24'h000000, aR} :
        (paddr == OFS_INDEX) ? {16'h0000, hxR} :
        (paddr == OFS_STACK) ? {16'h0000, spR} :
        (paddr == OFS_PROG) ? {16'h0000, pcR} :
        (paddr == OFS_CCR) ? {24'h000000, ccrView} :
        (paddr == OFS_STAT) ? statWord : 32'h00000000;
    assign prdata = (psel & ~pwrite) ? rdMux : 32'h00000000;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // stack and vector traffic; high index byte is left out of the frame
    wire [7:0] pushByte = (idxR == 3'd0) ? pcR[7:0] :
        (idxR == 3'd1) ? pcR[15:8] :
        (idxR == 3'd2) ? hxR[7:0] :
        (idxR == 3'd3) ? aR : ccrView;
    wire lastByte = (idxR == 3'(STACK_BYTES - 1));
    assign memReq = (stR == ST_STACK) | (stR == ST_UNSTACK) |
        (stR == ST_VEC_HI) | (stR == ST_VEC_LO);
    assign memWe = (stR == ST_STACK);
    assign memWdata = pushByte;
    assign memAddr = (stR == ST_STACK) ? spR :
        (stR == ST_UNSTACK) ? spR + 16'h0001 :
        vecR + {15'h0000, stR == ST_VEC_LO};
    assign irqAck = irqStart | waitWake | (stopDone & irqAny);
    assign irqId = irqSel;

    always_comb begin
        stNxt = stR;
        aNxt = aR;
        hxNxt = hxR;
        spNxt = spR;
        pcNxt = pcR;
        ccrNxt = ccrR;
        irNxt = irR;
        vecNxt = vecR;
        idxNxt = idxR;
        brkNxt = brkR;
        dlyNxt = dlyR;
        wakeNxt = wakeR;
        if (apbWr) begin
            case (paddr)
                OFS_WORK: aNxt = pwdata[7:0];
                OFS_INDEX: hxNxt = pwdata[15:0];
                OFS_STACK: spNxt = pwdata[15:0];
                OFS_PROG: pcNxt = pwdata[15:0];
                // software may raise the mask here but never drop it
                OFS_CCR: ccrNxt = pwdata[7:0] | CCR_ONES | {4'h0, iBit, 3'b000};
                default: ;
            endcase
        end
        case (stR)
            ST_RUN: begin
                if (pcLoad) begin
                    pcNxt = pcLoadVal;
                end else if (pcInc) begin
                    pcNxt = pcR + 16'h0001;
                end
                if (irLoad) begin
                    irNxt = irVal;
                end
                if (alu.valid) begin
                    if (aluWr) begin
                        aNxt = aluRes;
                    end
                    if (aluNz) begin
                        ccrNxt[CCR_N] = aluRes[7];
                        ccrNxt[CCR_Z] = (aluRes == 8'h00);
                    end
                    if (updC) begin
                        ccrNxt[CCR_C] = aluC;
                    end
                    if (updV) begin
                        ccrNxt[CCR_V] = aluV;
                    end
                    if (updH) begin
                        ccrNxt[CCR_H] = aluH;
                    end
                end
                if (hxLoad) begin
                    hxNxt = hxVal;
                end
                if (stackLowReinit) begin
                    spNxt = {spR[15:8], SP_LOW_REINIT};
                end else if (spLoad) begin
                    spNxt = spVal;
                end else if (spPush) begin
                    spNxt = spR - 16'h0001;
                end else if (spPull) begin
                    spNxt = spR + 16'h0001;
                end
                if (maskClearOp) begin
                    ccrNxt[CCR_I] = 1'b0;
                end else if (maskSetOp) begin
                    ccrNxt[CCR_I] = 1'b1;
                end
                idxNxt = 3'd0;
                if (brkStart) begin
                    irNxt = SWI_OPCODE;
                    vecNxt = monMode ? VEC_BRK_MON : VEC_BRK;
                    brkNxt = 1'b1;
                    stNxt = ST_STACK;
                end else if (irqStart) begin
                    vecNxt = irqVec;
                    stNxt = ST_STACK;
                end else if (interruptReturnOp) begin
                    stNxt = ST_UNSTACK;
                end else if (waitOp) begin
                    ccrNxt[CCR_I] = 1'b0;
                    stNxt = ST_WAIT;
                end else if (stopOp) begin
                    ccrNxt[CCR_I] = 1'b0;
                    wakeNxt = 1'b0;
                    dlyNxt = 16'h0000;
                    stNxt = ST_STOP;
                end
            end
            ST_STACK: begin
                if (memAck) begin
                    spNxt = spR - 16'h0001;
                    idxNxt = idxR + 3'd1;
                    if (lastByte) begin
                        ccrNxt[CCR_I] = 1'b1;
                        stNxt = ST_VEC_HI;
                    end
                end
            end
            ST_VEC_HI: begin
                if (memAck) begin
                    pcNxt[15:8] = memRdata;
                    stNxt = ST_VEC_LO;
                end
            end
            ST_VEC_LO: begin
                if (memAck) begin
                    pcNxt[7:0] = memRdata;
                    stNxt = ST_RUN;
                end
            end
            ST_UNSTACK: begin
                if (memAck) begin
                    spNxt = spR + 16'h0001;
                    idxNxt = idxR + 3'd1;
                    case (idxR)
                        3'd0: ccrNxt = memRdata | CCR_ONES;
                        3'd1: aNxt = memRdata;
                        3'd2: hxNxt[7:0] = memRdata;
                        3'd3: pcNxt[15:8] = memRdata;
                        default: pcNxt[7:0] = memRdata;
                    endcase
                    if (lastByte) begin
                        brkNxt = brkR & brkReq;
                        stNxt = ST_RUN;
                    end
                end
            end
            ST_WAIT: begin
                if (waitWake) begin
                    vecNxt = irqVec;
                    idxNxt = 3'd0;
                    stNxt = ST_STACK;
                end
            end
            ST_STOP: begin
                if (stopDone) begin
                    vecNxt = irqVec;
                    idxNxt = 3'd0;
                    stNxt = irqAny ? ST_STACK : ST_RUN;
                end else if (wakeR) begin
                    dlyNxt = dlyR + 16'h0001;
                end else if (|(irqPend & IRQ_EXT)) begin
                    wakeNxt = 1'b1;
                end
            end
            default: stNxt = ST_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stR <= ST_VEC_HI;
            vecR <= VEC_RESET;
            spR <= SP_RESET;
            ccrR <= CCR_RESET;
            aR <= 8'h00;
            hxR <= 16'h0000;
            pcR <= 16'h0000;
            irR <= 8'h00;
            idxR <= 3'd0;
            brkR <= 1'b0;
            wakeR <= 1'b0;
            dlyR <= 16'h0000;
        end else begin
            stR <= stNxt;
            vecR <= vecNxt;
            spR <= spNxt;
            ccrR <= ccrNxt;
            aR <= aNxt;
            hxR <= hxNxt;
            pcR <= pcNxt;
            irR <= irNxt;
            idxR <= idxNxt;
            brkR <= brkNxt;
            wakeR <= wakeNxt;
            dlyR <= dlyNxt;
        end
    end

    assign workReg = aR;
    assign indexPair = hxR;
    assign stackPtr = spR;
    assign progCnt = pcR;
    assign ccrOut = ccrView;
    assign instrReg = irR;
    assign brkActive = brkR;
    // clock stays gated through the whole recovery count
    assign cpuClkEn = (stR != ST_WAIT) & (stR != ST_STOP);

    chk_sp_reset: assert property (@(posedge clk) $rose(rstn) |-> spR == SP_RESET)
        else $error("stack pointer not preset after reset");
    chk_rsp_low: assert property (@(posedge clk) disable iff (!rstn)
        run && stackLowReinit |=> spR[7:0] == SP_LOW_REINIT && spR[15:8] == $past(spR[15:8]))
        else $error("stack low reinit wrong");
    chk_push_dec: assert property (@(posedge clk) disable iff (!rstn)
        stR == ST_STACK && memAck |=> spR == $past(spR) - 16'h0001)
        else $error("stack pointer not decremented on push");
    chk_pc_inc: assert property (@(posedge clk) disable iff (!rstn)
        run && pcInc && !pcLoad |=> pcR == $past(pcR) + 16'h0001)
        else $error("program counter not advanced");
    chk_reset_vec: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> stR == ST_VEC_HI && memReq && memAddr == VEC_RESET)
        else $error("reset vector not fetched");
    chk_ccr_ones: assert property (@(posedge clk) disable iff (!rstn)
        psel && !pwrite && paddr == OFS_CCR |-> prdata[6:5] == 2'b11)
        else $error("ccr bits six and five not one");
    chk_mask_entry: assert property (@(posedge clk) disable iff (!rstn)
        $past(stR) == ST_STACK && stR == ST_VEC_HI |-> iBit && spR == $past(spR) - 16'h0001)
        else $error("mask not set between stacking and vector");
    chk_mask_hold: assert property (@(posedge clk) disable iff (!rstn)
        $fell(iBit) |-> $past(run && (maskClearOp || waitOp || stopOp)) ||
            $past(stR) == ST_UNSTACK)
        else $error("mask cleared by other means");
    chk_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
        run && alu.valid && aluNz |=> ccrR[CCR_Z] == ($past(aluRes) == 8'h00))
        else $error("zero flag wrong");
    chk_brk_vec: assert property (@(posedge clk) disable iff (!rstn)
        brkStart |=> irR == SWI_OPCODE && vecR == ($past(monMode) ? VEC_BRK_MON : VEC_BRK))
        else $error("break entry wrong");
    chk_wait_clk: assert property (@(posedge clk) disable iff (!rstn)
        run && waitOp && !brkStart && !irqStart && !interruptReturnOp |=>
            stR == ST_WAIT && !cpuClkEn && !iBit)
        else $error("wait entry wrong");
endmodule : cpmst_core

// File: cpmst_mem_model.sv
// cpmst_mem_model: behavioural memory on the far side of the cpu state block.
// assumes one clock; each request gets a one-cycle ack, later when slow is high.
`timescale 1ns/10ps
module cpmst_mem_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata,
    output logic memAck
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_r;
    logic ack_r;
    // idle data inverted so a stale byte never passes for a real answer
    assign memRdata = ack_r ? mem[memAddr] : ~mem[memAddr];
    assign memAck = ack_r;
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = a[7:0] ^ a[15:8];
        end
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            wait_r <= 2'h0;
        end else if (memReq && !ack_r && wait_r == {slow, 1'b0}) begin
            ack_r <= 1'b1;
            wait_r <= 2'h0;
            if (memWe) begin
                mem[memAddr] <= memWdata;
            end
        end else begin
            ack_r <= 1'b0;
            wait_r <= (memReq && !ack_r) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule : cpmst_mem_model

// File: cpu_programming_model_state_tb_top.sv
// cpu_programming_model_state_tb_top: self-checking bench of the cpu state block.
// assumes cpmst_mem_model as memory; sequencer pulses come from one vector.
`timescale 1ns/10ps
module cpu_programming_model_state_tb_top;
    import cpmst_pkg::*;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irqAck, brkReq, monMode, se;
    logic brkActive, memReq, memWe, memAck, cpuClkEn, slow, sb;
    logic [7:0] paddr, irVal, memWdata, memRdata, workReg, ccrOut, instrReg, a, m, fm;
    logic [15:0] pcLoadVal, hxVal, spVal, memAddr, indexPair, stackPtr, progCnt, sp0, pc0;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] irqPend, irqId;
    logic [14:0] pul;
    wire logic instrEnd, pcInc, pcLoad, irLoad, hxLoad, spLoad, spPush, spPull;
    wire logic stackLowReinit, maskClearOp, maskSetOp, interruptReturnOp, waitOp, stopOp;
    wire logic brkLastCycle;
    cpmst_alu_t alu;
    int err_total, n_compared, seed, i;
    assign {brkLastCycle, stopOp, waitOp, interruptReturnOp, maskSetOp, maskClearOp,
        stackLowReinit, spPull, spPush, spLoad, hxLoad, irLoad, pcLoad, pcInc, instrEnd} = pul;
    cpmst_core #(.STOP_CYC(4), .SWI_OPCODE(8'ha5)) i_dut (.*);
    cpmst_mem_model i_mem (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] pat(input logic [15:0] x);
        return x[7:0] ^ x[15:8];
    endfunction : pat
    function automatic logic [15:0] vec(input logic [15:0] x);
        return {pat(x), pat(x + 16'h1)};
    endfunction : vec
    function automatic logic [7:0] addCcr(input logic [7:0] p, q, input logic sb);
        logic [8:0] s;
        logic [7:0] f;
        s = sb ? {1'b0, p} - {1'b0, q} : {1'b0, p} + {1'b0, q};
        f = 8'h00;
        f[CCR_C] = s[8];
        f[CCR_Z] = (s[7:0] == 8'h00);
        f[CCR_N] = s[7];
        f[CCR_H] = ({1'b0, p[3:0]} + {1'b0, q[3:0]}) > 5'hf;
        f[CCR_V] = (p[7] == (q[7] ^ sb)) && (s[7] != p[7]);
        return f;
    endfunction : addCcr
    task chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task pulse(input int b);
        @(posedge clk);
        pul <= 15'h1 << b;
        @(posedge clk);
        pul <= 15'h0;
        #1;
    endtask : pulse
    task waitRun;
        int k;
        k = 0;
        do begin
            apb(1'b0, OFS_STAT, 32'h0);
            k++;
        end while (r[2:0] !== ST_RUN && k < 300);
        chk(r[2:0], ST_RUN);
    endtask : waitRun
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim;
    end
    initial begin
        {seed, err_total, n_compared} = {32'h3596, 64'h0};
        {rstn, psel, penable, pwrite, paddr, pwdata, pul, irVal} = '0;
        {pcLoadVal, hxVal, spVal, alu, irqPend, brkReq, monMode, slow} = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        waitRun;
        chk(stackPtr, SP_RESET);
        chk(ccrOut, CCR_RESET);
        chk(progCnt, vec(VEC_RESET));
        $display("reset test done");
        a = 8'($random(seed));
        apb(1'b1, OFS_WORK, {24'h0, a});
        apb(1'b0, OFS_WORK, 32'h0);
        chk(r, {24'h0, a});
        hxVal = 16'($random(seed));
        pulse(4);
        chk(indexPair, hxVal);
        apb(1'b0, 8'h18, 32'h0);
        chk(se, 1'b1);
        apb(1'b1, OFS_CCR, 32'h0);
        chk(ccrOut, CCR_RESET);
        pulse(9);
        chk(ccrOut[CCR_I], 1'b0);
        irVal = 8'($random(seed));
        pulse(3);
        chk(instrReg, irVal);
        pulse(6);
        chk(stackPtr, 16'h00fe);
        pulse(7);
        chk(stackPtr, SP_RESET);
        spVal = {8'h02, 8'($random(seed))};
        pulse(5);
        pulse(8);
        chk(stackPtr, {8'h02, SP_LOW_REINIT});
        pc0 = progCnt;
        pulse(1);
        chk(progCnt, pc0 + 16'h1);
        pcLoadVal = 16'($random(seed));
        pulse(2);
        chk(progCnt, pcLoadVal);
        $display("register test done");
        for (i = 0; i < 10; i++) begin
            sb = i > 1 && i[0];
            a = i == 0 ? 8'hff : i == 1 ? 8'h7f : i == 3 ? 8'h80 : 8'($random(seed));
            m = i < 2 || i == 3 ? 8'h01 : 8'($random(seed));
            // subtraction leaves the nibble carry alone, so it is masked there
            fm = sb ? 8'h87 : 8'h97;
            apb(1'b1, OFS_WORK, {24'h0, a});
            @(posedge clk);
            alu <= '{1'b1, sb ? ALU_SUB : ALU_ADD, m, 1'b0};
            @(posedge clk);
            alu.valid <= 1'b0;
            #1;
            chk(workReg, sb ? 8'(a - m) : 8'(a + m));
            chk(ccrOut & fm, addCcr(a, m, sb) & fm);
            chk(ccrOut[6:5], 2'b11);
        end
        $display("alu test done");
        sp0 = stackPtr;
        pc0 = progCnt;
        @(posedge clk);
        irqPend <= 4'b0110;
        slow <= 1'b1;
        #1;
        chk(irqId, 4'h1);
        pulse(0);
        waitRun;
        chk(progCnt, vec(16'hfff8));
        chk(ccrOut[CCR_I], 1'b1);
        chk(stackPtr, sp0 - 16'h5);
        chk(i_mem.mem[sp0 - 16'h3], workReg);
        chk(i_mem.mem[sp0 - 16'h2], indexPair[7:0]);
        chk(i_mem.mem[sp0 - 16'h5], pat(sp0 - 16'h5));
        pulse(0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(r[2:0], ST_RUN);
        @(posedge clk);
        irqPend <= 4'h0;
        pulse(11);
        waitRun;
        chk(stackPtr, sp0);
        chk(progCnt, pc0);
        chk(ccrOut[CCR_I], 1'b0);
        $display("interrupt test done");
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            monMode <= i[0];
            brkReq <= 1'b1;
            slow <= ~i[0];
            pulse(14);
            waitRun;
            chk(instrReg, 8'ha5);
            chk(progCnt, vec(i[0] ? VEC_BRK_MON : VEC_BRK));
            chk(brkActive, 1'b1);
            @(posedge clk);
            brkReq <= i[0];
            pulse(11);
            waitRun;
            chk(brkActive, i[0]);
        end
        $display("break test done");
        pulse(10);
        sp0 = stackPtr;
        pulse(12);
        chk(cpuClkEn, 1'b0);
        chk(ccrOut[CCR_I], 1'b0);
        @(posedge clk);
        irqPend <= 4'b1000;
        brkReq <= 1'b0;
        #1;
        chk(irqAck, 1'b1);
        waitRun;
        chk(progCnt, vec(16'hfff4));
        chk(i_mem.mem[sp0 - 16'h4][CCR_I], 1'b0);
        @(posedge clk);
        irqPend <= 4'h0;
        pulse(11);
        waitRun;
        chk(brkActive, 1'b0);
        pulse(10);
        pulse(13);
        chk(cpuClkEn, 1'b0);
        chk(ccrOut[CCR_I], 1'b0);
        @(posedge clk);
        irqPend <= 4'b0001;
        repeat (2) @(posedge clk);
        #1;
        chk(cpuClkEn, 1'b0);
        waitRun;
        chk(progCnt, vec(VEC_IRQ_TOP));
        $display("low power test done");
        @(posedge clk);
        irqPend <= 4'h0;
        pulse(12);
        chk(cpuClkEn, 1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        waitRun;
        chk(ccrOut[CCR_I], 1'b1);
        chk(stackPtr, SP_RESET);
        $display("reset exit test done");
        end_sim;
    end
endmodule : cpu_programming_model_state_tb_top
